// ---- common/cfg_pkg.sv ----
// constants of the sensor output configuration register bank
// assumes one 20 MHz clock domain; serial pins are synchronised inside
package cfg_pkg;
  localparam int NREG = 45;
  // chip id: read id is write id with the top bit set
  localparam logic [7:0] ID_READ_BIT = 8'h80;
  localparam logic [6:0] ID_FIRST = 7'h02;
  localparam logic [6:0] ID_LAST = 7'h06;
  localparam logic [7:0] PAGE_BASE = 8'h30;
  localparam logic [7:0] OB_LINES_RST = 8'h0a;
  localparam logic [15:0] REG_ADDR [NREG] = '{
    16'h3046, 16'h3048, 16'h3049, 16'h304b, 16'h305c, 16'h305d, 16'h305e, 16'h305f,
    16'h309e, 16'h309f, 16'h3128, 16'h3129, 16'h313b, 16'h315e, 16'h3164, 16'h317c,
    16'h31ec, 16'h3405, 16'h3407, 16'h3414, 16'h3418, 16'h3419, 16'h3441, 16'h3442,
    16'h3443, 16'h3444, 16'h3445, 16'h3446, 16'h3447, 16'h3448, 16'h3449, 16'h344a,
    16'h344b, 16'h344c, 16'h344d, 16'h344e, 16'h344f, 16'h3450, 16'h3451, 16'h3452,
    16'h3453, 16'h3454, 16'h3455, 16'h3472, 16'h3473};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'he1, 8'h00, 8'h08, 8'h00, 8'h0c, 8'h00, 8'h10, 8'h01,
    8'h5a, 8'h5a, 8'h05, 8'h1d, 8'h51, 8'h1b, 8'h1b, 8'h12,
    8'h37, 8'h20, 8'h03, OB_LINES_RST, 8'h49, 8'h04, 8'h0c, 8'h0c,
    8'h03, 8'h40, 8'h4a, 8'h47, 8'h00, 8'h1f, 8'h00, 8'h17,
    8'h00, 8'h0f, 8'h00, 8'h17, 8'h00, 8'h47, 8'h00, 8'h0f,
    8'h00, 8'h0f, 8'h00, 8'h9c, 8'h07};
  // writable bits; all others are fixed at their reset value
  localparam logic [7:0] REG_WMASK [NREG] = '{
    8'hf1, 8'h30, 8'h30, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h30, 8'h03, 8'h3f, 8'hff, 8'h1f, 8'hff, 8'hff,
    8'h03, 8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff,
    8'h01, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff,
    8'h01, 8'hff, 8'h01, 8'hff, 8'h1f};
  // register indices
  localparam int IX_PORT = 0;
  localparam int IX_VSW = 1;
  localparam int IX_HSW = 2;
  localparam int IX_PIN = 3;
  localparam int IX_CKA = 4;
  localparam int IX_TUNA = 8;
  localparam int IX_DEPA = 11;
  localparam int IX_CKE = 13;
  localparam int IX_CKF = 14;
  localparam int IX_DEPB = 15;
  localparam int IX_DEPC = 16;
  localparam int IX_REP = 17;
  localparam int IX_WIRED = 18;
  localparam int IX_OB = 19;
  localparam int IX_VSIZE = 20;
  localparam int IX_DT = 22;
  localparam int IX_LANE = 24;
  localparam int IX_MCLK = 25;
  localparam int IX_TIM = 27;
  localparam int IX_HSIZE = 43;
  localparam int N_TIM = 8;
  localparam int TIMING_W = 9 * N_TIM;
  // field positions
  localparam int PORT_LSB = 4;
  localparam int WIDTH_LSB = 4;
  localparam int VPIN_LSB = 0;
  localparam int HPIN_LSB = 2;
  localparam int REP_LSB = 4;
  // field codes
  localparam logic [3:0] PORT_LVDS2 = 4'hd;
  localparam logic [3:0] PORT_LVDS4 = 4'he;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h3;
  localparam logic [1:0] PIN_HIGH = 2'h0;
  localparam logic [1:0] PIN_SYNC = 2'h2;
  // horizontal pulse grows by this many clocks per width code
  localparam logic [5:0] HS_STEP_CYC = 6'h08;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ADDR = 4'b0010,
    S_DATA = 4'b0100,
    S_SKIP = 4'b1000
  } ser_phase_e;
endpackage

// ---- common/ser_if.sv ----
// byte level link between serial pin shifter and register control
// assumes both ends on mclk
`timescale 1ns/1ps
interface ser_if;
  logic byte_stb;
  logic [7:0] rx_byte;
  logic sel_act;
  logic tx_en;
  logic tx_load;
  logic [7:0] tx_byte;
  modport shifter (output byte_stb, rx_byte, sel_act, input tx_en, tx_load, tx_byte);
  modport ctrl (input byte_stb, rx_byte, sel_act, output tx_en, tx_load, tx_byte);
endinterface

// ---- rtl/sensor_output_config_regs.sv ----
// output, sync and csi-2 configuration register bank of an image sensor
// reached over the 4-wire serial link; timing pulses come from mclk logic
`timescale 1ns/1ps
module sensor_output_config_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // 4-wire serial pins
  input wire logic ser_clk,
  input wire logic ser_sel_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  // timing generator
  input wire logic master_mode,
  input wire logic frame_start,
  input wire logic line_start,
  // sync pins
  output logic vertical_sync_pin,
  output logic vertical_sync_oe,
  output logic horizontal_sync_pin,
  output logic horizontal_sync_oe,
  // decoded selections
  output logic lvds_four_ch,
  output logic port_sel_bad,
  output logic csi_four_lane,
  output logic lane_sel_bad,
  output logic sync_sel_bad,
  // settings to the datapath
  output logic [47:0] clock_settings,
  output logic [31:0] tuning_values,
  output logic [23:0] depth_tuning,
  output logic [1:0] csi_repeat_ctrl,
  output logic [1:0] wired_lane_count,
  output logic [5:0] ob_line_count,
  output logic [12:0] vert_out_size,
  output logic [12:0] horiz_out_size,
  output logic [15:0] data_type_format,
  output logic [15:0] master_clock_frequency,
  output logic [cfg_pkg::TIMING_W-1:0] dphy_timing
);
  import cfg_pkg::*;

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    ser_phase_e ph;
    logic [2:0] page;
    logic rd;
    logic [7:0] addr;
    logic ld;
    logic lvds4;
    logic pbad;
    logic lane4;
    logic lbad;
    logic sbad;
  } ctl_s;

  ctl_s s;
  ctl_s next_s;
  ser_if bus ();

  // reset image of the whole bank, built from the constant tables
  function automatic logic [NREG-1:0][7:0] rst_image();
    logic [NREG-1:0][7:0] r;
    r = '0;
    for (int i = 0; i < NREG; i++) begin
      r[i] = REG_RST[i];
    end
    return r;
  endfunction

  localparam logic [NREG-1:0][7:0] RST_IMG = rst_image();

  // page and in-page offset to the flat register address
  function automatic logic [15:0] full_addr(input logic [2:0] pg, input logic [7:0] a);
    logic [7:0] hi;
    hi = 8'(PAGE_BASE + {5'h00, pg});
    return {hi, a};
  endfunction

  // {hit, index}; reserved and unlisted addresses miss
  function automatic logic [6:0] find_reg(input logic [15:0] a);
    logic [6:0] r;
    r = '0;
    for (int i = 0; i < NREG; i++) begin
      if (REG_ADDR[i] == a) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  // fixed bits keep their reset value whatever is written
  function automatic logic [7:0] merge(input logic [5:0] ix, input logic [7:0] wd);
    return (wd & REG_WMASK[ix]) | (REG_RST[ix] & ~REG_WMASK[ix]);
  endfunction

  // read value; a miss reads as zero
  function automatic logic [7:0] rd_val(input logic [NREG-1:0][7:0] rg,
                                        input logic [2:0] pg, input logic [7:0] a);
    logic [6:0] f;
    f = find_reg(full_addr(pg, a));
    return f[6] ? rg[f[5:0]] : 8'h00;
  endfunction

  logic [6:0] wr_hit;
  logic [6:0] id7;
  logic [3:0] port_code;
  logic [1:0] lane_code;
  logic [1:0] vpin_code;
  logic [1:0] hpin_code;

  always_comb begin
    next_s = s;
    next_s.ld = 1'b0;
    id7 = bus.rx_byte[6:0];
    wr_hit = find_reg(full_addr(s.page, s.addr));
    if (!bus.sel_act) begin
      // deselect ends the frame in any phase
      next_s.ph = S_IDLE;
      next_s.rd = 1'b0;
    end else if (bus.byte_stb) begin
      case (s.ph)
        S_IDLE: begin
          if (id7 >= ID_FIRST && id7 <= ID_LAST) begin
            next_s.page = 3'(id7 - ID_FIRST);
            next_s.rd = |(bus.rx_byte & ID_READ_BIT);
            next_s.ph = S_ADDR;
          end else begin
            // foreign chip id: ignore the rest of the frame
            next_s.ph = S_SKIP;
          end
        end
        S_ADDR: begin
          next_s.addr = bus.rx_byte;
          next_s.ld = s.rd;
          next_s.ph = S_DATA;
        end
        S_DATA: begin
          if (!s.rd && wr_hit[6]) begin
            next_s.regs[wr_hit[5:0]] = merge(wr_hit[5:0], bus.rx_byte);
          end
          // auto increment stays inside the page
          next_s.addr = s.addr + 8'h01;
          next_s.ld = s.rd;
        end
        S_SKIP: begin
          next_s.ph = S_SKIP;
        end
        default: begin
          next_s.ph = S_IDLE;
        end
      endcase
    end
    port_code = next_s.regs[IX_PORT][PORT_LSB +: 4];
    lane_code = next_s.regs[IX_LANE][1:0];
    vpin_code = next_s.regs[IX_PIN][VPIN_LSB +: 2];
    hpin_code = next_s.regs[IX_PIN][HPIN_LSB +: 2];
    next_s.lvds4 = (port_code == PORT_LVDS4);
    next_s.pbad = (port_code != PORT_LVDS2) && (port_code != PORT_LVDS4);
    next_s.lane4 = (lane_code == LANE_4);
    next_s.lbad = (lane_code != LANE_2) && (lane_code != LANE_4);
    next_s.sbad = (vpin_code != PIN_HIGH && vpin_code != PIN_SYNC) ||
                  (hpin_code != PIN_HIGH && hpin_code != PIN_SYNC);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.regs <= RST_IMG;
      s.ph <= S_IDLE;
      s.lvds4 <= 1'b1;
      s.lane4 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // read data is fetched in the same cycle the address settles; ld is registered with it
  assign bus.tx_load = s.ld;
  assign bus.tx_byte = rd_val(s.regs, s.page, s.addr);
  assign bus.tx_en = s.rd && (s.ph == S_DATA);

  serial_shifter u_shifter (
    .mclk(mclk),
    .arst_n(arst_n),
    .ser_clk(ser_clk),
    .ser_sel_n(ser_sel_n),
    .ser_din(ser_din),
    .ser_dout(ser_dout),
    .ser_dout_oe(ser_dout_oe),
    .bus(bus.shifter)
  );

  sync_pin_driver u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .master_mode(master_mode),
    .frame_start(frame_start),
    .line_start(line_start),
    .vs_width(s.regs[IX_VSW][WIDTH_LSB +: 2]),
    .hs_width(s.regs[IX_HSW][WIDTH_LSB +: 2]),
    .vs_sel(s.regs[IX_PIN][VPIN_LSB +: 2]),
    .hs_sel(s.regs[IX_PIN][HPIN_LSB +: 2]),
    .vsync_pin(vertical_sync_pin),
    .vsync_oe(vertical_sync_oe),
    .hsync_pin(horizontal_sync_pin),
    .hsync_oe(horizontal_sync_oe)
  );

  assign lvds_four_ch = s.lvds4;
  assign port_sel_bad = s.pbad;
  assign csi_four_lane = s.lane4;
  assign lane_sel_bad = s.lbad;
  assign sync_sel_bad = s.sbad;

  // input clock settings, first page then second page
  assign clock_settings = {s.regs[IX_CKF], s.regs[IX_CKE], s.regs[IX_CKA + 3],
                           s.regs[IX_CKA + 2], s.regs[IX_CKA + 1], s.regs[IX_CKA]};
  assign tuning_values = {s.regs[IX_TUNA + 4], s.regs[IX_TUNA + 2],
                          s.regs[IX_TUNA + 1], s.regs[IX_TUNA]};
  assign depth_tuning = {s.regs[IX_DEPC], s.regs[IX_DEPB], s.regs[IX_DEPA]};

  // csi-2 transmitter settings
  assign csi_repeat_ctrl = s.regs[IX_REP][REP_LSB +: 2];
  assign wired_lane_count = s.regs[IX_WIRED][1:0];
  assign ob_line_count = s.regs[IX_OB][5:0];
  assign vert_out_size = {s.regs[IX_VSIZE + 1][4:0], s.regs[IX_VSIZE]};
  assign horiz_out_size = {s.regs[IX_HSIZE + 1][4:0], s.regs[IX_HSIZE]};
  assign data_type_format = {s.regs[IX_DT + 1], s.regs[IX_DT]};
  assign master_clock_frequency = {s.regs[IX_MCLK + 1], s.regs[IX_MCLK]};

  // each phy timing: low byte at even slot, bit 8 in bit 0 of the next
  always_comb begin
    dphy_timing = '0;
    for (int k = 0; k < N_TIM; k++) begin
      dphy_timing[k * 9 +: 9] = {s.regs[IX_TIM + 2 * k + 1][0],
                                 s.regs[IX_TIM + 2 * k]};
    end
  end

endmodule

// ---- rtl/serial_shifter.sv ----
// 4-wire serial pin shifter: synchronises pins, assembles and sends bytes
// assumes serial clock idles low and runs at most mclk/16
`timescale 1ns/1ps
module serial_shifter (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // pins
  input wire logic ser_clk,
  input wire logic ser_sel_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  // byte side
  ser_if.shifter bus
);
  import cfg_pkg::*;
  typedef struct packed {
    logic [2:0] m1;
    logic [2:0] m2;
    logic ck_d;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [7:0] tx;
    logic stb;
    logic dout;
    logic oe;
  } shf_s;
  shf_s s;
  shf_s next_s;
  logic rise;
  logic fall;
  always_comb begin
    next_s = s;
    next_s.m1 = {ser_clk, ser_sel_n, ser_din};
    next_s.m2 = s.m1;
    next_s.ck_d = s.m2[2];
    next_s.stb = 1'b0;
    rise = s.m2[2] & ~s.ck_d;
    fall = ~s.m2[2] & s.ck_d;
    if (s.m2[1]) begin
      next_s.bitc = 3'h0;
    end else if (rise) begin
      next_s.sh = {s.sh[6:0], s.m2[0]};
      next_s.bitc = s.bitc + 3'h1;
      next_s.stb = (s.bitc == 3'h7);
    end else if (fall && s.bitc != 3'h0) begin
      // no shift on the falling edge that ends a byte: the reload has already set bit 7
      next_s.dout = s.tx[7];
      next_s.tx = {s.tx[6:0], 1'b0};
    end
    if (bus.tx_load) begin
      next_s.dout = bus.tx_byte[7];
      next_s.tx = {bus.tx_byte[6:0], 1'b0};
    end
    next_s.oe = bus.tx_en & ~s.m2[1];
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.m1 <= 3'b010;
      s.m2 <= 3'b010;
    end else begin
      s <= next_s;
    end
  end
  assign bus.byte_stb = s.stb;
  assign bus.rx_byte = s.sh;
  assign bus.sel_act = ~s.m2[1];
  assign ser_dout = s.dout;
  assign ser_dout_oe = s.oe;
endmodule

// ---- rtl/sync_pin_driver.sv ----
// master mode sync pin generator with programmable pulse widths
// assumes frame_start coincides with a line_start pulse
`timescale 1ns/1ps
module sync_pin_driver (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // timing
  input wire logic master_mode,
  input wire logic frame_start,
  input wire logic line_start,
  // settings
  input wire logic [1:0] vs_width,
  input wire logic [1:0] hs_width,
  input wire logic [1:0] vs_sel,
  input wire logic [1:0] hs_sel,
  // pins
  output logic vsync_pin,
  output logic vsync_oe,
  output logic hsync_pin,
  output logic hsync_oe
);
  import cfg_pkg::*;
  typedef struct packed {
    logic [3:0] vcnt;
    logic [5:0] hcnt;
    logic vp;
    logic vo;
    logic hp;
    logic ho;
  } drv_s;
  drv_s s;
  drv_s next_s;
  always_comb begin
    next_s = s;
    if (frame_start) begin
      next_s.vcnt = 4'h1 << vs_width;
    end else if (line_start && s.vcnt != 4'h0) begin
      next_s.vcnt = s.vcnt - 4'h1;
    end
    if (line_start) begin
      next_s.hcnt = 6'(({4'h0, hs_width} + 6'h1) * HS_STEP_CYC);
    end else if (s.hcnt != 6'h0) begin
      next_s.hcnt = s.hcnt - 6'h1;
    end
    // slave mode: pins released, width fields have no effect
    next_s.vo = master_mode;
    next_s.ho = master_mode;
    // prohibited pin codes hold the pin high like code 0
    next_s.vp = !(vs_sel == PIN_SYNC && next_s.vcnt != 4'h0);
    next_s.hp = !(hs_sel == PIN_SYNC && next_s.hcnt != 6'h0);
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.vp <= 1'b1;
      s.hp <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign vsync_pin = s.vp;
  assign vsync_oe = s.vo;
  assign hsync_pin = s.hp;
  assign hsync_oe = s.ho;
endmodule

// ---- verification/host_model.sv ----
// host end of the 4-wire serial link: framing, byte shifting, read capture
// assumes a 20 MHz mclk; serial clock runs at mclk/20 and idles low
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic mclk,
  // serial pins
  output logic ser_clk,
  output logic ser_sel_n,
  output logic ser_din,
  input wire logic ser_dout
);
  initial begin
    ser_clk = 1'b0;
    ser_sel_n = 1'b1;
    ser_din = 1'b0;
  end
  // msb first; read data taken just before each rising edge
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      ser_din <= tx[i];
      repeat (9) @(posedge mclk);
      @(negedge mclk);
      rx[i] = ser_dout;
      @(posedge mclk);
      ser_clk <= 1'b1;
      repeat (10) @(posedge mclk);
      ser_clk <= 1'b0;
    end
  endtask
  // data bytes go low byte first, the device steps the address
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [15:0] wd,
                      input int n, output logic [15:0] q);
    logic [7:0] id;
    logic [7:0] b;
    id = {rd, 7'(a[15:8] - 8'h2e)};
    q = '0;
    @(posedge mclk);
    ser_sel_n <= 1'b0;
    repeat (4) @(posedge mclk);
    shift(id, b);
    shift(a[7:0], b);
    for (int k = 0; k < n; k++) begin
      // toggling filler while the device owns the data phase
      shift(rd ? 8'h55 : wd[8*k +: 8], b);
      q[8*k +: 8] = b;
    end
    repeat (14) @(posedge mclk);
    ser_sel_n <= 1'b1;
    ser_din <= ~ser_din;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// ---- verification/sensor_output_config_properties.sv ----
// timing and decode properties of the register bank's ports
// assumes one mclk domain; bound onto the top module
`timescale 1ns/1ps
module sensor_output_config_props (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial and timing
  input wire logic ser_sel_n,
  input wire logic ser_dout_oe,
  input wire logic master_mode,
  input wire logic frame_start,
  input wire logic line_start,
  // sync pins
  input wire logic vertical_sync_pin,
  input wire logic vertical_sync_oe,
  input wire logic horizontal_sync_pin,
  input wire logic horizontal_sync_oe,
  // decodes and settings
  input wire logic lvds_four_ch,
  input wire logic port_sel_bad,
  input wire logic csi_four_lane,
  input wire logic lane_sel_bad,
  input wire logic [15:0] data_type_format
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic live;
  logic [5:0] hs_low;
  logic [3:0] vs_lines;
  // live masks the first edge, where $past still sees reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      live <= 1'b0;
      hs_low <= 6'h00;
      vs_lines <= 4'h0;
    end else begin
      live <= 1'b1;
      hs_low <= horizontal_sync_pin ? 6'h00 : hs_low + 6'h01;
      vs_lines <= vertical_sync_pin ? 4'h0 : vs_lines + 4'(line_start);
    end
  end
  chk_oe_follow: assert property (live |-> vertical_sync_oe == $past(master_mode) &&
    horizontal_sync_oe == $past(master_mode)) else $error("sync oe not following mode");
  chk_vs_start: assert property ($fell(vertical_sync_pin) |-> $past(frame_start))
    else $error("vertical pulse without frame start");
  chk_hs_start: assert property ($fell(horizontal_sync_pin) |-> $past(line_start))
    else $error("horizontal pulse without line start");
  chk_vs_lines: assert property ($rose(vertical_sync_pin) |-> vs_lines inside {1, 2, 4, 8})
    else $error("vertical pulse line count wrong");
  chk_hs_width: assert property ($rose(horizontal_sync_pin) |-> hs_low[2:0] == 3'h0)
    else $error("horizontal pulse not a width step");
  chk_hs_bound: assert property ($fell(horizontal_sync_pin) |-> ##[8:32] horizontal_sync_pin)
    else $error("horizontal pulse too long");
  chk_port_decode: assert property (lvds_four_ch |-> !port_sel_bad)
    else $error("four channel code flagged bad");
  chk_lane_decode: assert property (csi_four_lane |-> !lane_sel_bad)
    else $error("four lane code flagged bad");
  chk_dout_release: assert property (ser_sel_n [*8] |=> !ser_dout_oe)
    else $error("read drive outside frame");
  chk_cfg_hold: assert property (ser_sel_n [*8] |=> $stable(data_type_format))
    else $error("setting changed outside frame");
  cov_vs_long: cover property ($rose(vertical_sync_pin) && vs_lines == 4'h8);
  cov_hs_wide: cover property ($rose(horizontal_sync_pin) && hs_low == 6'h20);
  cov_read: cover property ($rose(ser_dout_oe));
endmodule
bind sensor_output_config_regs sensor_output_config_props chk_i (.mclk, .arst_n,
  .ser_sel_n, .ser_dout_oe, .master_mode, .frame_start, .line_start, .vertical_sync_pin,
  .vertical_sync_oe, .horizontal_sync_pin, .horizontal_sync_oe, .lvds_four_ch,
  .port_sel_bad, .csi_four_lane, .lane_sel_bad, .data_type_format);

// ---- verification/tb_top.sv ----
// self-checking bench of the sensor output configuration register bank
// assumes host_model owns the serial pins; sync timing pulses come from here
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  import cfg_pkg::*;
  localparam int LINE = 40;
  logic mclk, arst_n, ser_clk, ser_sel_n, ser_din, ser_dout, ser_dout_oe;
  logic master_mode, frame_start, line_start, lvds_four_ch, port_sel_bad;
  logic vertical_sync_pin, vertical_sync_oe, horizontal_sync_pin, horizontal_sync_oe;
  logic csi_four_lane, lane_sel_bad, sync_sel_bad;
  logic [47:0] clock_settings;
  logic [31:0] tuning_values;
  logic [23:0] depth_tuning;
  logic [1:0] csi_repeat_ctrl, wired_lane_count;
  logic [5:0] ob_line_count;
  logic [12:0] vert_out_size, horiz_out_size;
  logic [15:0] data_type_format, master_clock_frequency, q;
  logic [TIMING_W-1:0] dphy_timing;
  // released data line reads inverted, so a read outside the drive window fails
  logic host_miso;
  assign host_miso = ser_dout_oe ? ser_dout : ~ser_dout;
  logic [3:0] pc [4] = '{4'hd, 4'h0, 4'hf, 4'he};
  int fails = 0;
  int cmp_count = 0;
  int vl, hl;
  sensor_output_config_regs uut (.mclk, .arst_n, .ser_clk, .ser_sel_n, .ser_din,
    .ser_dout, .ser_dout_oe, .master_mode, .frame_start, .line_start, .vertical_sync_pin,
    .vertical_sync_oe, .horizontal_sync_pin, .horizontal_sync_oe, .lvds_four_ch,
    .port_sel_bad, .csi_four_lane, .lane_sel_bad, .sync_sel_bad, .clock_settings,
    .tuning_values, .depth_tuning, .csi_repeat_ctrl, .wired_lane_count, .ob_line_count,
    .vert_out_size, .horiz_out_size, .data_type_format, .master_clock_frequency,
    .dphy_timing);
  host_model host (.mclk, .ser_clk, .ser_sel_n, .ser_din, .ser_dout(host_miso));
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input int n);
    host.xfer(1'b0, a, d, n, q);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    host.xfer(1'b1, a, 16'h0000, n, q);
  endtask
  // one frame of nine lines; horizontal width taken from the first line only
  task automatic measure();
    vl = 0;
    hl = 0;
    for (int k = 0; k < 9 * LINE; k++) begin
      @(posedge mclk);
      frame_start <= (k == 0);
      line_start <= (k % LINE == 0);
      // pins sampled mid-cycle, clear of the edge that moves them
      @(negedge mclk);
      vl += (vertical_sync_pin === 1'b0);
      hl += (k < LINE && horizontal_sync_pin === 1'b0);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    master_mode = 1'b0;
    frame_start = 1'b0;
    line_start = 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("clock_settings", 48'h1b1b0110000c, clock_settings)
    `CHK("dphy_timing", {9'h017, 9'h01f, 9'h047}, dphy_timing[26:0])
    `CHK("tuning_values", 32'h51055a5a, tuning_values)
    `CHK("csi_repeat_ctrl", 2'h2, csi_repeat_ctrl)
    `CHK("wired_lane_count", 2'h3, wired_lane_count)
    `CHK("vert_out_size", 13'h0449, vert_out_size)
    for (int i = 0; i < NREG; i++) begin
      rd(REG_ADDR[i], 1);
      `CHK("reset readback", REG_RST[i], q[7:0])
    end
    wr(16'h3048, 16'h00cf, 1);
    rd(16'h3048, 1);
    `CHK("fixed bits readback", 8'h00, q[7:0])
    rd(16'h304c, 1);
    `CHK("reserved readback", 8'h00, q[7:0])
    wr(16'h315e, 16'h001a, 1);
    wr(16'h3164, 16'h001a, 1);
    `CHK("clock_settings", 16'h1a1a, clock_settings[47:32])
    wr(16'h3444, 16'h2520, 2);
    rd(16'h3444, 2);
    `CHK("master clock readback", 16'h2520, q)
    `CHK("master_clock_frequency", 16'h2520, master_clock_frequency)
    wr(16'h3129, 16'h0000, 1);
    wr(16'h317c, 16'h0000, 1);
    wr(16'h31ec, 16'h000e, 1);
    `CHK("depth_tuning", 24'h0e0000, depth_tuning)
    wr(16'h3441, 16'h0a0a, 2);
    `CHK("data_type_format", 16'h0a0a, data_type_format)
    // reset in mid-run with the link idle brings the bank back to its defaults
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("data_type_format", 16'h0c0c, data_type_format)
    `CHK("master_clock_frequency", 16'h4a40, master_clock_frequency)
    wr(16'h3472, 16'hffff, 2);
    rd(16'h3472, 2);
    `CHK("horiz readback", 16'h1fff, q)
    `CHK("horiz_out_size", 13'h1fff, horiz_out_size)
    wr(16'h3414, 16'h00ff, 1);
    `CHK("ob_line_count", 6'h3f, ob_line_count)
    wr(16'h3446, 16'hffff, 2);
    rd(16'h3446, 2);
    `CHK("timing readback", 16'h01ff, q)
    `CHK("dphy_timing", 9'h1ff, dphy_timing[8:0])
    foreach (pc[i]) begin
      wr(16'h3046, {8'h00, pc[i], 4'h1}, 1);
      `CHK("lvds_four_ch", pc[i] == 4'he, lvds_four_ch)
      `CHK("port_sel_bad", !(pc[i] inside {4'hd, 4'he}), port_sel_bad)
    end
    for (int c = 0; c < 4; c++) begin
      wr(16'h3443, 16'(c), 1);
      `CHK("csi_four_lane", c == 3, csi_four_lane)
      `CHK("lane_sel_bad", c % 2 == 0, lane_sel_bad)
    end
    master_mode <= 1'b1;
    wr(16'h304b, 16'h000a, 1);
    for (int w = 0; w < 4; w++) begin
      wr(16'h3048, 16'(w << 4), 1);
      wr(16'h3049, 16'(w << 4 | 8), 1);
      measure();
      `CHK("vertical low cycles", (1 << w) * LINE, vl)
      `CHK("horizontal low cycles", (w + 1) * 8, hl)
    end
    wr(16'h304b, 16'h0000, 1);
    measure();
    `CHK("pins held high", 0, vl + hl)
    wr(16'h304b, 16'h0005, 1);
    measure();
    `CHK("sync_sel_bad", 1'b1, sync_sel_bad)
    `CHK("prohibited pin code", 0, vl + hl)
    master_mode <= 1'b0;
    wr(16'h304b, 16'h000a, 1);
    `CHK("slave oe", 2'b00, {vertical_sync_oe, horizontal_sync_oe})
    print_verdict();
  end
endmodule
